// File: acm_pkg.sv
// Shared constants and carrier types for the audio clock manager
package acm_pkg;
  localparam int unsigned SYS_CLK_HZ      = 125_000_000;
  localparam int unsigned REF_MIN_HZ      = 7_000;
  localparam int unsigned REF_MAX_HZ      = 30_000_000;
  localparam int unsigned REF_DIV_W       = 12;
  localparam int unsigned FB_MUL_W        = 10;
  localparam int unsigned OUT_DIV_W       = 10;
  localparam int unsigned PERIOD_W        = 30;
  localparam int unsigned EDGES_PER_OS    = 8;
  localparam int unsigned ALT_INC         = 4;
  localparam int unsigned PROC_PER_OS     = 2;
  localparam int unsigned FS_HALF_LOW     = 64;
  localparam int unsigned FS_HALF_HIGH    = 96;
  localparam int unsigned LOCK_TOLERANCE  = 2;
  localparam int unsigned REF_MAX_GAP     = (SYS_CLK_HZ + REF_MIN_HZ - 1) / REF_MIN_HZ;
  localparam int unsigned MIN_HALF_CYCLES = SYS_CLK_HZ / REF_MAX_HZ / 2;

  typedef struct packed {
    logic                 ratio_high_select;
    logic                 ext_clock_select;
    logic                 pll_run_enable;
    logic                 lock_irq_enable;
    logic [REF_DIV_W-1:0] ref_divisor;
    logic [FB_MUL_W-1:0]  feedback_multiplier;
    logic [OUT_DIV_W-1:0] divided_clock_out_divisor;
  } acm_ctl_t;

  typedef struct packed {
    logic pll_unsettled;
    logic lock_irq;
    logic loop_filter_out;
  } acm_stat_t;
endpackage

// File: acm_edge_div.sv
// Tick-driven toggle divider; a divisor of zero means two to the width
`timescale 1ns/1ns
module acm_edge_div
  import acm_pkg::*;
#(
  parameter int unsigned W = 10
)
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] divisor,
  output logic              div_out,
  output logic              div_rise
);
  logic [W-1:0] count;
  logic         wrap;

  assign wrap     = tick && (count + W'(1) == divisor);
  assign div_rise = wrap && !div_out;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count   <= '0;
      div_out <= 1'b0;
    end
    else if (clear)
    begin
      count   <= '0;
      div_out <= 1'b0;
    end
    else if (wrap)
    begin
      count   <= '0;
      div_out <= !div_out;
    end
    else if (tick)
    begin
      count <= count + W'(1);
    end
  end
endmodule

// File: acm_clock_manager.sv
// Clock manager: ratio multiplier, oversample mux, processor and output clocks
`timescale 1ns/1ns
// Contract
// R1: Oversample clock is reference over divisor times multiplier
// R2: Reference from 7 kHz to 30 MHz accepted
// R3: Loop spans roughly 25 to 55 kHz rates
// R4: 27 MHz reference reaches 32/44.1/48 kHz
// R5: Ratio select feeds 128x or 192x to DAC
// R6: Select set means 192x, clear means 128x
// R7: Processor clock is four times oversample clock
// R8: External select picks alternate clock over loop
// R9: Alternate clock halved; must be 256x or 384x
// R10: Output clock is processor over divisor, halved
// R11: Output clock spans processor/2 to processor/2048
// R12: Run low holds control low; second loop follows
// R13: Software sets run enable after reset to lock
// R14: Unsettled flag low on lock, high on loss
// R15: Unsettled rising edge raises lock interrupt if enabled
// R16: Lock indication synchronised before status and edge use
module acm_clock_manager
  import acm_pkg::*;
#(
  parameter int unsigned REF_TIMEOUT = REF_MAX_GAP * (1 << REF_DIV_W)
)
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire logic      ref_clock_in,
  input  wire logic      alt_clock_in,
  input  wire acm_ctl_t  ctl,
  output acm_stat_t      stat,
  output logic           processor_clock,
  output logic           oversample_clock,
  output logic           sample_rate_clock,
  output logic           divided_clock_out
);
  localparam int unsigned WIN_W = REF_DIV_W + 1;

  logic [1:0]          ref_sync;
  logic [1:0]          alt_sync;
  logic                ref_last;
  logic                alt_last;
  logic                src_edge;
  logic [WIN_W-1:0]    win_len;
  logic [WIN_W-1:0]    edge_cnt;
  logic [PERIOD_W-1:0] gap_cnt;
  logic [PERIOD_W-1:0] period;
  logic                win_end;
  logic                timed_out;
  logic                lock_raw;
  logic [1:0]          lock_sync;
  logic                unsettled_last;
  logic [PERIOD_W-1:0] nco_acc;
  logic [PERIOD_W-1:0] nco_inc;
  logic [PERIOD_W-1:0] next_acc;
  logic                nco_tick;
  logic                loop_live;
  logic                proc_rise;
  logic                os_rise;
  logic [OUT_DIV_W-1:0] fs_half;

  function automatic logic [PERIOD_W-1:0] abs_diff(input logic [PERIOD_W-1:0] a,
                                                   input logic [PERIOD_W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // Pins arrive unrelated to ref_clk; only the second stage is looked at
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ref_sync <= '0;
      alt_sync <= '0;
      ref_last <= 1'b0;
      alt_last <= 1'b0;
    end
    else
    begin
      ref_sync <= {ref_sync[0], ref_clock_in};
      alt_sync <= {alt_sync[0], alt_clock_in};
      ref_last <= ref_sync[1];
      alt_last <= alt_sync[1];
    end
  end

  // Source mux: alternate clock measured per edge, which halves it downstream
  assign src_edge = ctl.ext_clock_select ? (alt_sync[1] && !alt_last) // R8
                                         : (ref_sync[1] && !ref_last); // R2
  // A zero divisor is taken as the full 4096 count
  assign win_len  = ctl.ext_clock_select ? WIN_W'(1)
                  : (ctl.ref_divisor == '0) ? WIN_W'(1 << REF_DIV_W)
                  : {1'b0, ctl.ref_divisor}; // R1
  assign win_end   = src_edge && (edge_cnt + WIN_W'(1) >= win_len);
  assign timed_out = (gap_cnt >= PERIOD_W'(REF_TIMEOUT));

  // Period measurement over a window of divisor reference edges, or of one alternate clock edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      edge_cnt    <= '0;
      gap_cnt     <= '0;
      period      <= '0;
      lock_raw    <= 1'b0;
    end
    else if (!ctl.pll_run_enable)
    begin
      edge_cnt    <= '0;
      gap_cnt     <= '0;
      period      <= '0;
      lock_raw    <= 1'b0; // R12
    end
    else if (win_end)
    begin
      edge_cnt    <= '0;
      gap_cnt     <= PERIOD_W'(1);
      period      <= gap_cnt + PERIOD_W'(1);
      lock_raw    <= (period != '0)
                  && (abs_diff(gap_cnt + PERIOD_W'(1), period) <= PERIOD_W'(LOCK_TOLERANCE));
    end
    else if (timed_out)
    begin
      // Reference has stopped: drop lock rather than freewheel
      edge_cnt <= '0;
      gap_cnt  <= '0;
      period   <= '0;
      lock_raw <= 1'b0; // R14
    end
    else
    begin
      gap_cnt <= gap_cnt + PERIOD_W'(1);
      if (src_edge)
      begin
        edge_cnt <= edge_cnt + WIN_W'(1);
      end
    end
  end

  // Numerically controlled oscillator, one tick per processor clock half period
  assign loop_live = ctl.pll_run_enable && (period != '0); // R12
  assign nco_inc   = ctl.ext_clock_select ? PERIOD_W'(ALT_INC) // R9
                   : PERIOD_W'(ctl.feedback_multiplier) * PERIOD_W'(EDGES_PER_OS); // R1 R7
  assign next_acc  = nco_acc + nco_inc;
  assign nco_tick  = loop_live && (next_acc >= period); // R3 R4

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      nco_acc         <= '0;
      processor_clock <= 1'b0;
    end
    else if (!loop_live)
    begin
      nco_acc         <= '0;
      processor_clock <= 1'b0;
    end
    else if (nco_tick)
    begin
      // Period can shrink a lot on relock; restart the phase instead of racing
      nco_acc         <= (next_acc - period >= period) ? '0 : next_acc - period;
      processor_clock <= !processor_clock; // R7
    end
    else
    begin
      nco_acc <= next_acc;
    end
  end

  assign proc_rise = nco_tick && !processor_clock;

  // Oversample clock: four processor cycles per cycle
  acm_edge_div #(.W(OUT_DIV_W)) u_os_div
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clear    (!loop_live),
    .tick     (proc_rise),
    .divisor  (OUT_DIV_W'(PROC_PER_OS)),
    .div_out  (oversample_clock), // R7
    .div_rise (os_rise)
  );

  // Oversample ratio decides how many oversample cycles make one sample
  assign fs_half = ctl.ratio_high_select ? OUT_DIV_W'(FS_HALF_HIGH) // R5 R6
                                         : OUT_DIV_W'(FS_HALF_LOW);

  acm_edge_div #(.W(OUT_DIV_W)) u_fs_div
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clear    (!loop_live),
    .tick     (os_rise),
    .divisor  (fs_half), // R5
    .div_out  (sample_rate_clock),
    .div_rise ()
  );

  // Programmable divider then toggle keeps the duty cycle at half
  acm_edge_div #(.W(OUT_DIV_W)) u_out_div
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clear    (!loop_live),
    .tick     (proc_rise),
    .divisor  (ctl.divided_clock_out_divisor), // R10 R11
    .div_out  (divided_clock_out),
    .div_rise ()
  );

  // Lock status resynchronised before it is reported or edge-detected
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lock_sync      <= '0;
      unsettled_last <= 1'b1;
    end
    else
    begin
      lock_sync      <= {lock_sync[0], lock_raw}; // R16
      unsettled_last <= !lock_sync[1];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stat <= '{pll_unsettled: 1'b1, lock_irq: 1'b0, loop_filter_out: 1'b0};
    end
    else
    begin
      stat.pll_unsettled   <= !lock_sync[1]; // R14
      stat.lock_irq        <= ctl.lock_irq_enable && !lock_sync[1] && !unsettled_last; // R15
      stat.loop_filter_out <= loop_live; // R12
    end
  end

  unlock_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // R14
    !lock_raw |-> ##3 stat.pll_unsettled)
    else $error("unsettled flag not raised after lock loss");

  lock_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // R16
    lock_raw [*3] |-> ##1 !stat.pll_unsettled)
    else $error("unsettled flag not cleared after lock");

  lock_irq_a: assert property (@(posedge ref_clk) disable iff (rst) // R15
    stat.lock_irq |-> $past(ctl.lock_irq_enable) && stat.pll_unsettled
                      && !$past(stat.pll_unsettled))
    else $error("lock interrupt without a rising unsettled edge");

  run_low_a: assert property (@(posedge ref_clk) disable iff (rst) // R12
    !ctl.pll_run_enable |=> !stat.loop_filter_out && !processor_clock && !lock_raw)
    else $error("loop active while run enable is low");

  proc_os_a: assert property (@(posedge ref_clk) disable iff (rst) // R7
    $rose(oversample_clock) |-> $past(proc_rise))
    else $error("oversample edge not on processor edge");

  window_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
    win_end && ctl.pll_run_enable |=> period != '0 && edge_cnt == '0)
    else $error("window close did not record a period");

  alt_half_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
    ctl.ext_clock_select && ctl.pll_run_enable && src_edge
      |=> edge_cnt == '0 && gap_cnt == PERIOD_W'(1))
    else $error("alternate clock not measured per edge");

  nco_range_a: assert property (@(posedge ref_clk) disable iff (rst) // R3
    loop_live && nco_inc < period |=> nco_acc < $past(period))
    else $error("oscillator accumulator out of range");

  ratio_a: assert property (@(posedge ref_clk) disable iff (rst) // R6
    loop_live && os_rise
      && u_fs_div.count == (ctl.ratio_high_select ? OUT_DIV_W'(FS_HALF_HIGH - 1)
                                                  : OUT_DIV_W'(FS_HALF_LOW - 1))
      |=> sample_rate_clock != $past(sample_rate_clock))
    else $error("sample clock half does not match the oversample ratio");

  lock_c: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(stat.pll_unsettled));
  irq_c: cover property (@(posedge ref_clk) disable iff (rst)
    stat.lock_irq);
  divided_clock_out_c: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(divided_clock_out));
  alt_c: cover property (@(posedge ref_clk) disable iff (rst)
    ctl.ext_clock_select && $rose(oversample_clock));
endmodule

// File: acm_osc_model.sv
// Reference and alternate oscillator pin model
`timescale 1ns/1ns
module acm_osc_model
(
  input  wire logic        ref_on,
  input  wire logic [15:0] ref_half,
  input  wire logic        alt_on,
  input  wire logic [15:0] alt_half,
  output logic             ref_clock_in,
  output logic             alt_clock_in
);
  initial
  begin
    ref_clock_in = 1'h0;
    alt_clock_in = 1'h0;
  end

  // Stopped pins finish their cycle and stand low
  always
  begin
    wait (ref_on);
    #(ref_half) ref_clock_in = 1'h1;
    #(ref_half) ref_clock_in = 1'h0;
  end

  always
  begin
    wait (alt_on);
    #(alt_half) alt_clock_in = 1'h1;
    #(alt_half) alt_clock_in = 1'h0;
  end
endmodule

// File: tb_audio_pll_clock_manager.sv
// Self-checking bench for the audio clock manager
`timescale 1ns/1ns
module tb_audio_pll_clock_manager
  import acm_pkg::*;
  ;
  logic        ref_clk;
  logic        rst;
  logic        ref_on;
  logic        alt_on;
  logic        ref_in;
  logic        alt_in;
  logic [15:0] ref_half;
  logic [15:0] alt_half;
  acm_ctl_t    ctl;
  acm_stat_t   stat;
  wire  [3:0]  clks;
  logic [3:0]  prev;
  int          n_mismatch;
  int          checked;
  int          cycles;
  int          irqs;
  int          n_in;
  int          cyc;
  int          k;

  acm_clock_manager #(.REF_TIMEOUT(2000)) dut
  (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .ref_clock_in      (ref_in),
    .alt_clock_in      (alt_in),
    .ctl               (ctl),
    .stat              (stat),
    .processor_clock   (clks[0]),
    .oversample_clock  (clks[1]),
    .sample_rate_clock (clks[2]),
    .divided_clock_out (clks[3])
  );

  acm_osc_model osc
  (
    .ref_on       (ref_on),
    .ref_half     (ref_half),
    .alt_on       (alt_on),
    .alt_half     (alt_half),
    .ref_clock_in (ref_in),
    .alt_clock_in (alt_in)
  );

  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  task results();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Worst case is near 50k cycles; ceiling leaves margin
  always @(posedge ref_clk)
  begin
    prev <= clks;
    cycles <= cycles + 1;
    if (stat.lock_irq === 1'h1)
      irqs <= irqs + 1;
    if (cycles == 90000)
    begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  task chk_num(input string what, input int exp, input int got, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic rose(input int i);
    return clks[i] === 1'h1 && prev[i] === 1'h0;
  endfunction

  // Period of clock o in cycles, and rises of clock i inside it
  task edges(input int o, input int i);
    int w;
    w = 0;
    n_in = 0;
    cyc = 0;
    do
    begin
      @(posedge ref_clk) #1;
      w++;
    end while (!rose(o) && w < 20000);
    do
    begin
      @(posedge ref_clk) #1;
      cyc++;
      if (rose(i))
        n_in++;
    end while (!rose(o) && cyc < 20000);
  endtask

  task wait_unsettled(input logic v, input int lim);
    int w;
    w = 0;
    while (stat.pll_unsettled !== v && w < lim)
    begin
      @(posedge ref_clk) #1;
      w++;
    end
    chk_bit("pll_unsettled", v, stat.pll_unsettled);
  endtask

  initial
  begin
    rst = 1'h1;
    ctl = '0;
    ref_on = 1'h0;
    alt_on = 1'h0;
    ref_half = 16'h00C8;
    alt_half = 16'h0050;
    cycles = 0;
    irqs = 0;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    ref_on <= 1'h1;
    ctl.ref_divisor <= 12'h002;
    ctl.feedback_multiplier <= 10'h004;
    ctl.divided_clock_out_divisor <= 10'h001;
    ctl.lock_irq_enable <= 1'h1;
    repeat (200) @(posedge ref_clk);
    #1 chk_bit("clocks idle", 1'h0, |clks);
    chk_bit("loop drive", 1'h0, stat.loop_filter_out);
    chk_bit("pll_unsettled", 1'h1, stat.pll_unsettled);
    $display("test idle done");
    @(posedge ref_clk) ctl.pll_run_enable <= 1'h1;
    wait_unsettled(1'h0, 3000);
    chk_bit("loop drive", 1'h1, stat.loop_filter_out);
    // 400 ns reference, M=2, N=4: 25 cycle oversample period
    edges(1, 0);
    chk_num("oversample period", 25, cyc, 2);
    chk_num("proc per oversample", 4, n_in, 0);
    $display("test lock done");
    for (k = 0; k < 2; k++)
    begin
      @(posedge ref_clk) ctl.ratio_high_select <= k[0];
      // Wait to the first rise drops the half in progress
      edges(2, 1);
      chk_num("fs divider", k ? 192 : 128, n_in, 0);
    end
    for (k = 1; k >= 0; k--)
    begin
      @(posedge ref_clk) ctl.divided_clock_out_divisor <= k[9:0];
      edges(3, 0);
      chk_num("divided_clock_out divide", k ? 2 : 2048, n_in, 0);
    end
    $display("test dividers done");
    for (k = 1; k >= 0; k--)
    begin
      @(posedge ref_clk);
      ref_on <= 1'h1;
      ctl.lock_irq_enable <= k[0];
      wait_unsettled(1'h0, 3000);
      cyc = irqs;
      @(posedge ref_clk) ref_on <= 1'h0;
      wait_unsettled(1'h1, 2200);
      repeat (5) @(posedge ref_clk);
      chk_num("lock irq pulses", k, irqs - cyc, 0);
    end
    $display("test lock loss done");
    @(posedge ref_clk);
    ctl.ext_clock_select <= 1'h1;
    alt_on <= 1'h1;
    // 160 ns alternate clock halved: 40 cycle oversample period
    edges(1, 0);
    edges(1, 0);
    chk_num("ext oversample period", 40, cyc, 2);
    chk_num("ext proc per oversample", 4, n_in, 0);
    $display("test external done");
    results();
  end
endmodule
